// >>> design/tped_detector.sv
// thermopile event detector: filters, four detectors, flags, interrupt
// and a classic wishbone register slave.
// assumes adc samples arrive on pins with a strobe clock from the adc
// side; data is held stable for a whole period around its rising edge.
//
// Overview of operation
// RULE1 - two object low-pass filters, own coefficients
// RULE2 - four detectors, each selectable as interrupt
// RULE3 - parameters change live without restart
// RULE4 - raw samples reported, detection uses differences
// RULE5 - presence is difference of selected path pair
// RULE6 - presence flag when difference exceeds threshold
// RULE7 - motion is fast filter change over interval
// RULE8 - motion flag when change exceeds threshold
// RULE9 - motion set captures slow filter value
// RULE10 - shock flag: ambient minus its filter
// RULE11 - object sample against limit gives crossing events
// RULE12 - polarity bit picks rising or falling crossing
// RULE13 - reading interrupt status clears interrupt
// RULE14 - new interrupt only on fresh crossing
// RULE15 - reset sets limit flag, interrupt active
// RULE16 - decode two-bit presence source selector
// RULE17 - masked flags raise interrupt until status read
// RULE18 - flags clear below threshold by hysteresis
// RULE19 - object limit comparator has 64 counts hysteresis
// RULE20 - coefficient from code, per-sample update, limit doubled
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module tped_detector #(
  parameter int OBJ_W      = 17,
  parameter int AMB_W      = 16,
  parameter int MOVE_STEP  = 1
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // adc sample link
  input  wire logic             adc_clk,
  input  wire logic [OBJ_W-1:0] raw_target_sample,
  input  wire logic [AMB_W-1:0] raw_die_temp_sample,
  // interrupt to host, active high level
  output logic                  int_out
);

  // ----------------------------------------------------------------
  // link synchronisers
  // ----------------------------------------------------------------
  logic             clk_s1;
  logic             clk_s2;
  logic             clk_s3;
  logic [OBJ_W-1:0] obj_s1;
  logic [OBJ_W-1:0] obj_s2;
  logic [AMB_W-1:0] amb_s1;
  logic [AMB_W-1:0] amb_s2;
  logic             take;
  logic             take_d;

  // data is stable across the edge, so per-bit two-stage sync is safe
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {clk_s3, clk_s2, clk_s1}         <= 3'h0;
      {obj_s2, obj_s1, amb_s2, amb_s1} <= '0;
    end
    else
    begin
      {clk_s3, clk_s2, clk_s1} <= {clk_s2, clk_s1, adc_clk};
      {obj_s2, obj_s1}         <= {obj_s1, raw_target_sample};
      {amb_s2, amb_s1}         <= {amb_s1, raw_die_temp_sample};
    end
  end

  assign take = clk_s2 & ~clk_s3;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [OBJ_W-1:0] target_raw;
  logic [AMB_W-1:0] die_raw;
  logic [11:0]      filter_tc;
  logic [7:0]       occ_thr;
  logic [7:0]       move_thr;
  logic [7:0]       jump_thr;
  logic [4:0]       int_mask;
  logic [4:0]       control;
  logic [15:0]      target_limit;
  logic [4:0]       int_status;
  logic [4:0]       chip_status;
  logic             bus_req;
  logic             wr_hit;
  logic             status_read;
  logic [31:0]      rd_word;
  logic [31:0]      wr_word;

  assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_hit      = bus_req & wb_we_i;
  assign status_read = bus_req & ~wb_we_i & (wb_adr_i == tped_pkg::REG_INT_STATUS);
  assign wr_word     = tped_pkg::merge32(rd_word, wb_dat_i, wb_sel_i); // unselected lanes kept

  // raw samples are kept unconverted for the host
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      target_raw <= '0;
      die_raw    <= '0;
      take_d     <= 1'b0;
    end
    else
    begin
      take_d <= take;
      if (take)
      begin
        target_raw <= obj_s2; // RULE4
        die_raw    <= amb_s2;
      end
    end
  end

  // configuration writes act on the next sample, the interrupt mask at once; no restart needed
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filter_tc    <= tped_pkg::RST_FILTER_TC;
      occ_thr      <= tped_pkg::RST_OCC_THR;
      move_thr     <= tped_pkg::RST_MOVE_THR;
      jump_thr     <= tped_pkg::RST_JUMP_THR;
      int_mask     <= tped_pkg::RST_INT_MASK;
      control      <= tped_pkg::RST_CONTROL;
      target_limit <= tped_pkg::RST_LIMIT;
    end
    else if (wr_hit) // RULE3
    begin
      unique case (wb_adr_i)
        tped_pkg::REG_FILTER_TC:    filter_tc    <= wr_word[11:0];
        tped_pkg::REG_OCC_THR:      occ_thr      <= wr_word[7:0];
        tped_pkg::REG_MOVE_THR:     move_thr     <= wr_word[7:0];
        tped_pkg::REG_JUMP_THR:     jump_thr     <= wr_word[7:0];
        tped_pkg::REG_INT_MASK:     int_mask     <= wr_word[4:0];
        tped_pkg::REG_CONTROL:      control      <= wr_word[4:0];
        tped_pkg::REG_TARGET_LIMIT: target_limit <= wr_word[15:0];
        default: ; // read-only or unmapped: write ignored
      endcase
    end
  end

  // ----------------------------------------------------------------
  // filters
  // ----------------------------------------------------------------
  logic [OBJ_W-1:0] fast_filtered_target;
  logic [OBJ_W-1:0] slow_filtered_target;
  logic [AMB_W-1:0] filtered_die_temp;
  logic [OBJ_W-1:0] captured_slow_target;

  // each filter steps once per adc sample
  tped_lowpass #(.DW(OBJ_W)) u_fast (
    .clock    (clock),
    .arst_n   (arst_n),
    .take     (take),
    .sample   (obj_s2),
    .sel_code (filter_tc[tped_pkg::TC_FAST_LSB +: 4]),
    .filtered (fast_filtered_target)
  );
  tped_lowpass #(.DW(OBJ_W)) u_slow (
    .clock    (clock),
    .arst_n   (arst_n),
    .take     (take),
    .sample   (obj_s2),
    .sel_code (filter_tc[tped_pkg::TC_SLOW_LSB +: 4]),
    .filtered (slow_filtered_target)
  );
  tped_lowpass #(.DW(AMB_W)) u_die (
    .clock    (clock),
    .arst_n   (arst_n),
    .take     (take),
    .sample   (amb_s2),
    .sel_code (filter_tc[tped_pkg::TC_DIE_LSB +: 4]),
    .filtered (filtered_die_temp)
  );

  // ----------------------------------------------------------------
  // detector values
  // ----------------------------------------------------------------
  logic signed [17:0]      occupancy_value;
  logic signed [17:0]      movement_value;
  logic signed [17:0]      die_jump_value;
  logic signed [17:0]      move_now;
  logic signed [17:0]      move_sel;
  logic                    move_primed;
  logic [17:0]             occ_mag;
  logic [17:0]             move_mag;
  logic [17:0]             jump_mag;
  logic [OBJ_W-1:0]        fast_prev;
  logic [OBJ_W-1:0]        occ_a;
  logic [OBJ_W-1:0]        occ_b;
  logic [3:0]              move_cnt;
  logic [3:0]              move_len;
  logic                    move_tick;
  logic [1:0]              occupancy_source_sel;
  logic                    target_limit_polarity;
  logic [17:0]             limit_x2;

  assign occupancy_source_sel  = control[tped_pkg::CTRL_SRC_LSB +: 2];
  assign target_limit_polarity = control[tped_pkg::CTRL_POLARITY];
  assign limit_x2              = {1'b0, target_limit, 1'b0}; // RULE20

  // pick the pair of paths whose difference gives presence
  always_comb
  begin
    occ_a = occupancy_source_sel[0] ? fast_filtered_target : target_raw; // RULE16
    occ_b = occupancy_source_sel[1] ? captured_slow_target : slow_filtered_target; // RULE16
    occupancy_value = $signed({1'b0, occ_a}) - $signed({1'b0, occ_b}); // RULE5
    die_jump_value  = $signed(18'(die_raw)) - $signed(18'(filtered_die_temp)); // RULE10
    // thresholds are symmetric, so magnitudes are compared
    occ_mag  = occupancy_value[17] ? 18'(-occupancy_value) : 18'(occupancy_value);
    move_now = move_primed ? $signed({1'b0, fast_filtered_target}) - $signed({1'b0, fast_prev})
                           : 18'sh00000; // RULE7
    move_sel = move_tick ? move_now : movement_value; // fresh difference on a tick
    move_mag = move_sel[17] ? 18'(-move_sel) : 18'(move_sel);
    jump_mag = die_jump_value[17] ? 18'(-die_jump_value) : 18'(die_jump_value);
  end

  // motion interval in samples: (code + 1) * step
  assign move_len  = 4'((control[tped_pkg::CTRL_INTERVAL_LSB +: 2] + 3'h1) * MOVE_STEP);
  assign move_tick = take_d & (move_cnt + 4'h1 >= move_len);

  // fast filter is sampled once per interval and differenced
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      move_cnt       <= '0;
      fast_prev      <= '0;
      movement_value <= '0;
      move_primed    <= 1'b0;
    end
    else if (take_d)
    begin
      move_cnt <= move_tick ? 4'h0 : move_cnt + 4'h1;
      if (move_tick)
      begin
        fast_prev      <= fast_filtered_target;
        movement_value <= move_now; // RULE7
        move_primed    <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // conditions, events and flags
  // ----------------------------------------------------------------
  logic [4:0] next_chip_status;
  logic [4:0] events;

  // live conditions with hysteresis, evaluated after each sample
  always_comb
  begin
    next_chip_status = chip_status;
    next_chip_status[0] = 1'b0;
    if (take_d)
    begin
      next_chip_status[tped_pkg::FLAG_OCC] =
        tped_pkg::hyst_flag(chip_status[tped_pkg::FLAG_OCC], occ_mag, occ_thr); // RULE6 RULE18
      next_chip_status[tped_pkg::FLAG_MOVE] =
        tped_pkg::hyst_flag(chip_status[tped_pkg::FLAG_MOVE], move_mag, move_thr); // RULE8 RULE18
      next_chip_status[tped_pkg::FLAG_JUMP] =
        tped_pkg::hyst_flag(chip_status[tped_pkg::FLAG_JUMP], jump_mag, jump_thr); // RULE10 RULE18
      // limit side band of 64 counts keeps noise from re-triggering
      if (target_limit_polarity) // RULE12
      begin
        if (chip_status[tped_pkg::FLAG_LIMIT])
          next_chip_status[tped_pkg::FLAG_LIMIT] =
            !((18'(target_raw) + tped_pkg::LIMIT_HYST) < limit_x2); // RULE19
        else
          next_chip_status[tped_pkg::FLAG_LIMIT] = 18'(target_raw) > limit_x2; // RULE11
      end
      else
      begin
        if (chip_status[tped_pkg::FLAG_LIMIT])
          next_chip_status[tped_pkg::FLAG_LIMIT] =
            !(18'(target_raw) > limit_x2 + tped_pkg::LIMIT_HYST); // RULE19
        else
          next_chip_status[tped_pkg::FLAG_LIMIT] = 18'(target_raw) < limit_x2; // RULE11
      end
    end
  end

  // only an inactive-to-active change is an event
  assign events = next_chip_status & ~chip_status; // RULE14
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      chip_status <= '0;
    else
      chip_status <= next_chip_status;
  end
  // freeze slow filter on the motion event
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      captured_slow_target <= '0;
    else if (events[tped_pkg::FLAG_MOVE])
      captured_slow_target <= slow_filtered_target; // RULE9
  end
  // sticky interrupt status; a new event wins over the read clear
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      int_status <= tped_pkg::RST_INT_STATUS; // RULE15
    else
      int_status <= (status_read ? 5'h00 : int_status) | events; // RULE13
  end
  // any masked flag drives the pin until the status read
  assign int_out = |(int_status & int_mask); // RULE2 RULE17

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // unmapped addresses read zero and are still acknowledged
  always_comb
  begin
    unique case (wb_adr_i)
      tped_pkg::REG_TARGET_RAW:   rd_word = 32'(target_raw);
      tped_pkg::REG_DIE_RAW:      rd_word = 32'(die_raw);
      tped_pkg::REG_FAST_FILT:    rd_word = 32'(fast_filtered_target);
      tped_pkg::REG_SLOW_FILT:    rd_word = 32'(slow_filtered_target);
      tped_pkg::REG_CAPTURED:     rd_word = 32'(captured_slow_target);
      tped_pkg::REG_DIE_FILT:     rd_word = 32'(filtered_die_temp);
      tped_pkg::REG_INT_STATUS:   rd_word = 32'(int_status);
      tped_pkg::REG_CHIP_STATUS:  rd_word = 32'(chip_status);
      tped_pkg::REG_FILTER_TC:    rd_word = 32'(filter_tc);
      tped_pkg::REG_OCC_THR:      rd_word = 32'(occ_thr);
      tped_pkg::REG_MOVE_THR:     rd_word = 32'(move_thr);
      tped_pkg::REG_JUMP_THR:     rd_word = 32'(jump_thr);
      tped_pkg::REG_INT_MASK:     rd_word = 32'(int_mask);
      tped_pkg::REG_CONTROL:      rd_word = 32'(control);
      tped_pkg::REG_TARGET_LIMIT: rd_word = 32'(target_limit);
      default:                    rd_word = 32'h0000_0000;
    endcase
  end

  // one wait state: ack the cycle after the request, drop it next cycle
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= rd_word;
    end
  end

endmodule // tped_detector

// >>> inc/tped_pkg.sv
// package of the thermopile event detector: register map, field layout,
// reset values, filter time-constant table and small shared helpers.
// assumes a 32-bit classic wishbone slave with word-aligned registers.
package tped_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_TARGET_RAW   = 8'h00;
  localparam logic [7:0] REG_DIE_RAW      = 8'h04;
  localparam logic [7:0] REG_FAST_FILT    = 8'h08;
  localparam logic [7:0] REG_SLOW_FILT    = 8'h0C;
  localparam logic [7:0] REG_CAPTURED     = 8'h10;
  localparam logic [7:0] REG_DIE_FILT     = 8'h14;
  localparam logic [7:0] REG_INT_STATUS   = 8'h18;
  localparam logic [7:0] REG_CHIP_STATUS  = 8'h1C;
  localparam logic [7:0] REG_FILTER_TC    = 8'h20;
  localparam logic [7:0] REG_OCC_THR      = 8'h24;
  localparam logic [7:0] REG_MOVE_THR     = 8'h28;
  localparam logic [7:0] REG_JUMP_THR     = 8'h2C;
  localparam logic [7:0] REG_INT_MASK     = 8'h30;
  localparam logic [7:0] REG_CONTROL      = 8'h34;
  localparam logic [7:0] REG_TARGET_LIMIT = 8'h38;

  // ----------------------------------------------------------------
  // flag bit positions (status and mask share them)
  // ----------------------------------------------------------------
  localparam int FLAG_JUMP  = 1;
  localparam int FLAG_MOVE  = 2;
  localparam int FLAG_OCC   = 3;
  localparam int FLAG_LIMIT = 4;
  localparam int FLAG_W     = 5;

  // control register fields
  localparam int CTRL_INTERVAL_LSB = 0;
  localparam int CTRL_SRC_LSB      = 2;
  localparam int CTRL_POLARITY     = 4;
  // filter time-constant register fields
  localparam int TC_FAST_LSB = 0;
  localparam int TC_SLOW_LSB = 4;
  localparam int TC_DIE_LSB  = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]  RST_INT_STATUS = 5'h10;
  localparam logic [4:0]  RST_INT_MASK   = 5'h10;
  localparam logic [11:0] RST_FILTER_TC  = 12'hA8B;
  localparam logic [7:0]  RST_OCC_THR    = 8'h32;
  localparam logic [7:0]  RST_MOVE_THR   = 8'h0A;
  localparam logic [7:0]  RST_JUMP_THR   = 8'h0A;
  localparam logic [4:0]  RST_CONTROL    = 5'h16;
  localparam logic [15:0] RST_LIMIT      = 16'hFFFF;

  // ----------------------------------------------------------------
  // detection constants
  // ----------------------------------------------------------------
  localparam logic [17:0] HYST_MIN   = 18'h00005;
  localparam logic [17:0] LIMIT_HYST = 18'h00040;
  localparam int          FILT_FRAC  = 14;

  // presence source selector codes
  typedef enum logic [1:0] {
    OCC_RAW_SLOW, OCC_FAST_SLOW, OCC_RAW_CAPT, OCC_FAST_CAPT
  } tped_occ_src_type;

  // time-constant select code to shift: coefficient is 2**-shift
  function automatic logic [3:0] tc_shift(input logic [3:0] code);
    case (code)
      4'hD:    tc_shift = 4'h2;
      4'hC:    tc_shift = 4'h3;
      4'hB:    tc_shift = 4'h4;
      4'hA:    tc_shift = 4'h5;
      4'h9:    tc_shift = 4'h6;
      4'h8:    tc_shift = 4'h7;
      4'h5:    tc_shift = 4'h8;
      4'h4:    tc_shift = 4'h9;
      4'h3:    tc_shift = 4'hA;
      4'h2:    tc_shift = 4'hB;
      4'h1:    tc_shift = 4'hC;
      default: tc_shift = 4'hD;
    endcase
  endfunction

  // set above threshold, clear below threshold less max(thr/8, 5)
  function automatic logic hyst_flag(input logic cond, input logic [17:0] mag,
                                     input logic [7:0] thr);
    logic [17:0] t;
    logic [17:0] off;
    t   = {10'h000, thr};
    off = (t >> 3) > HYST_MIN ? (t >> 3) : HYST_MIN;
    if (cond)
      hyst_flag = !((mag + off) < t);
    else
      hyst_flag = mag > t;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge32(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      merge32[8*i +: 8] = sel[i] ? dat[8*i +: 8] : old[8*i +: 8];
  endfunction

endpackage

// >>> design/tped_lowpass.sv
// first-order recursive low-pass filter with a shift coefficient.
// assumes take is a one-cycle strobe on clock; first sample preloads.
`timescale 1ns/10ps
module tped_lowpass #(
  parameter int DW = 17
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // sample in
  input  wire logic          take,
  input  wire logic [DW-1:0] sample,
  input  wire logic [3:0]    sel_code,
  // filtered out
  output logic      [DW-1:0] filtered
);

  localparam int FW = tped_pkg::FILT_FRAC;

  logic [DW+FW-1:0]        acc;
  logic                    primed;
  logic signed [DW+FW:0]   diff;
  logic signed [DW+FW:0]   step;

  // y += (x - y) * 2**-k equals x*S + y*(1-S) with S = 2**-k
  always_comb
  begin
    diff = $signed({1'b0, sample, {FW{1'b0}}}) - $signed({1'b0, acc});
    step = diff >>> tped_pkg::tc_shift(sel_code); // RULE20
  end

  // accumulator keeps fraction bits so slow filters do not stall
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc    <= '0;
      primed <= 1'b0;
    end
    else if (take)
    begin
      primed <= 1'b1;
      if (!primed)
        acc <= {sample, {FW{1'b0}}};
      else
        acc <= acc + step[DW+FW-1:0]; // RULE1
    end
  end

  assign filtered = acc[DW+FW-1:FW];

endmodule // tped_lowpass

// >>> tb/tped_asserts.sv
// checker: bus handshake and interrupt behaviour at the detector pins
// assumes it is bound to tped_detector and samples on clock
`timescale 1ns/10ps
module tped_asserts (
  // clock and reset
  input wire logic        clock,
  input wire logic        arst_n,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // link and interrupt
  input wire logic        adc_clk,
  input wire logic        int_out
);
  logic [3:0] idle_cnt;
  logic       adc_last;
  // cycles since the link clock moved; a sample may still land below 8
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idle_cnt <= 4'h0;
      adc_last <= 1'h0;
    end
    else
    begin
      adc_last <= adc_clk;
      idle_cnt <= (adc_clk != adc_last) ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'hF};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_rdata_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
    |=> $stable(wb_dat_o)) else $error("read data moved");
  chk_int_power: assert property ($rose(arst_n) |-> int_out)
    else $error("interrupt low after reset");
  chk_int_hold: assert property (int_out && !(wb_cyc_i && wb_stb_i) |=> int_out)
    else $error("interrupt dropped without access");
  chk_int_clear: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
    wb_adr_i == tped_pkg::REG_INT_STATUS && idle_cnt > 4'h7 |=> !int_out)
    else $error("interrupt kept after status read");
  chk_int_fresh: assert property ($rose(int_out) |-> wb_ack_o || idle_cnt < 4'h8)
    else $error("interrupt rose without event");
endmodule // tped_asserts

bind tped_detector tped_asserts u_tped_asserts (.clock(clock), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_clk(adc_clk), .int_out(int_out));

// >>> tb/tped_adc_model.sv
// stand-in for the adc: strobe clock and paired samples
// assumes the detector samples the link on clock; link clock idles low
`timescale 1ns/10ps
module tped_adc_model (
  // clock
  input wire logic    clock,
  // link
  output logic        adc_clk,
  output logic [16:0] raw_target_sample,
  output logic [15:0] raw_die_temp_sample
);
  initial
  begin
    adc_clk = 1'h0;
    raw_target_sample = 17'h00000;
    raw_die_temp_sample = 16'h0000;
  end
  // one 120 ns frame, data 40 ns each side of the rise; afterwards the
  // lines invert so a stale value never passes for a fresh one
  task automatic send(input logic [16:0] tgt, input logic [15:0] die);
    @(posedge clock);
    raw_target_sample <= tgt;
    raw_die_temp_sample <= die;
    repeat (4) @(posedge clock);
    adc_clk <= 1'h1;
    repeat (4) @(posedge clock);
    adc_clk <= 1'h0;
    raw_target_sample <= ~tgt;
    raw_die_temp_sample <= ~die;
    repeat (4) @(posedge clock);
  endtask
endmodule // tped_adc_model

// >>> tb/tb.sv
// testbench: register access, filters, detectors and interrupt
// assumes tped_detector with default parameters and the adc model
`timescale 1ns/10ps
module tb;
  logic        clock;
  logic        arst_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat;
  logic [31:0] wb_dat_o;
  logic        wb_ack;
  logic        adc_clk;
  logic [16:0] tgt;
  logic [15:0] die;
  logic        int_out;
  logic [31:0] q;
  int          err_total = 0;
  int          samples_checked = 0;
  logic [7:0]  reg_adr [7] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38};
  logic [31:0] reg_rst [7] = '{32'hA8B, 32'h32, 32'h0A, 32'h0A, 32'h10, 32'h16, 32'hFFFF};
  logic [16:0] lim_raw [8] = '{17'h1400, 17'h1401, 17'h13C0, 17'h13BF,
                               17'h1440, 17'h13FF, 17'h1440, 17'h1441};
  logic [7:0]  lim_pol = 8'h0F;
  logic [7:0]  lim_exp = 8'h66;
  tped_detector u_tped_detector (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .adc_clk(adc_clk),
    .raw_target_sample(tgt), .raw_die_temp_sample(die), .int_out(int_out));
  tped_adc_model u_tped_adc_model (.clock(clock), .adc_clk(adc_clk),
    .raw_target_sample(tgt), .raw_die_temp_sample(die));
  // ----------------------------------------------------------------
  // checks and bus cycles
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle; ack and read data taken at one rising edge, released there
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clock);
    while (wb_ack !== 1'h1 && n < 20)
    begin
      n++;
      @(posedge clock);
    end
    if (wb_ack !== 1'h1)
    begin
      err_total++;
      finish_test();
    end
    q = wb_dat_o;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    xfer(1'h0, a, 32'h0);
    chk_val(q & m, e);
  endtask
  task automatic chk_int(input logic e);
    chk_val({31'h0, int_out}, {31'h0, e});
  endtask
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    arst_n = 1'h0;
    wb_cyc = 1'h0;
    wb_stb = 1'h0;
    wb_we = 1'h0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    repeat (3) @(posedge clock);
    arst_n <= 1'h1;
    chk_int(1'h1);
    for (int i = 0; i < 7; i++)
      rd(reg_adr[i], reg_rst[i]);
    rd(8'h3C, 32'h0);
    xfer(1'h1, 8'h00, 32'h1);
    rd(8'h00, 32'h0);
    rd(8'h18, 32'h10);
    chk_int(1'h0);
    rd(8'h18, 32'h0);
    // fast k2, slow k7, die k5; motion every sample, fast minus slow
    xfer(1'h1, 8'h20, 32'hA8D);
    xfer(1'h1, 8'h34, 32'h14);
    xfer(1'h1, 8'h30, 32'h0E);
    u_tped_adc_model.send(17'h01000, 16'h3000);
    xfer(1'h0, 8'h18, 32'h0);
    u_tped_adc_model.send(17'h01400, 16'h3100);
    chk_int(1'h1);
    rd(8'h00, 32'h1400);
    rd(8'h04, 32'h3100);
    rd(8'h08, 32'h1100);
    rd(8'h0C, 32'h1008);
    rd(8'h10, 32'h1008);
    rd(8'h1C, 32'h0E);
    rd(8'h18, 32'h0E);
    chk_int(1'h0);
    u_tped_adc_model.send(17'h01400, 16'h3100);
    chk_int(1'h0);
    // limit doubled to 0x1400; polarity changed on the fly
    xfer(1'h1, 8'h38, 32'h0A00);
    xfer(1'h1, 8'h30, 32'h10);
    xfer(1'h0, 8'h18, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'h1, 8'h34, lim_pol[i] ? 32'h14 : 32'h04);
      u_tped_adc_model.send(lim_raw[i], 16'h3100);
      rd(8'h1C, {27'h0, lim_exp[i], 4'h0}, 32'h10);
    end
    chk_int(1'h1);
    rd(8'h18, 32'h10, 32'h10);
    finish_test();
  end
endmodule // tb
